// ---- design/ais_scaler.sv ----
// Summary of operation
// - Add channel offset to raw before dividing.
// - Divide corrected reading; quotient is scaled output.
// - Both count entries read back two.
// - Divisors accept any signed nonzero value.
// - Separate divisor per channel, own channel only.
// - Separate offset per channel, own channel only.
// - Reset offset and divisor give raw count.
module ais_scaler
  import ais_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Raw converter counts, same clock domain.
  input wire ais_pair_type raw_in,
  // Register port.
  input wire logic [AIS_AW-1:0] addr_in,
  input wire logic [AIS_DW-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [AIS_DW-1:0] rd_data_out,
  // Scaled analog values.
  output ais_pair_type scaled_out
);

  // ----------------------------------------------------------------
  // Configuration registers and read port
  // ----------------------------------------------------------------
  ais_pair_type off_reg;            // Signed offsets.
  ais_pair_type off_next;
  ais_pair_type div_reg;            // Signed divisors, never zero.
  ais_pair_type div_next;
  ais_pair_type scaled_reg;         // Published results.
  ais_pair_type scaled_next;
  logic [AIS_DW-1:0] rd_data_reg;   // Read answer, valid one cycle.
  logic [AIS_DW-1:0] rd_data_next;

  // Decode writes and reads; a read answers only in the next cycle.
  always_comb begin
    off_next = off_reg;
    div_next = div_reg;
    rd_data_next = AIS_ZERO;
    if (wr_en_in) begin
      unique case (addr_in)
        AIS_ADDR_OFF_ONE: begin
          off_next.one = wr_data_in;
        end
        AIS_ADDR_OFF_TWO: begin
          off_next.two = wr_data_in;
        end
        AIS_ADDR_DIV_ONE: begin
          // A zero divisor would make the quotient meaningless, so drop it.
          if (wr_data_in != AIS_ZERO) begin
            div_next.one = wr_data_in;
          end
        end
        AIS_ADDR_DIV_TWO: begin
          if (wr_data_in != AIS_ZERO) begin
            div_next.two = wr_data_in;
          end
        end
        default: begin
          // Count entries, results and holes ignore writes.
        end
      endcase
    end
    if (rd_en_in) begin
      unique case (addr_in)
        AIS_ADDR_OFF_CNT: rd_data_next = AIS_CHAN_COUNT;
        AIS_ADDR_DIV_CNT: rd_data_next = AIS_CHAN_COUNT;
        AIS_ADDR_OFF_ONE: rd_data_next = off_reg.one;
        AIS_ADDR_OFF_TWO: rd_data_next = off_reg.two;
        AIS_ADDR_DIV_ONE: rd_data_next = div_reg.one;
        AIS_ADDR_DIV_TWO: rd_data_next = div_reg.two;
        AIS_ADDR_RES_ONE: rd_data_next = scaled_reg.one;
        AIS_ADDR_RES_TWO: rd_data_next = scaled_reg.two;
        default: rd_data_next = AIS_ZERO;  // Unmapped reads return zero.
      endcase
    end
  end

  // Register the configuration and the read answer.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      // Offset zero and divisor one pass the raw count through unchanged.
      off_reg <= '{two: AIS_OFF_RST, one: AIS_OFF_RST};
      div_reg <= '{two: AIS_DIV_RST, one: AIS_DIV_RST};
      rd_data_reg <= AIS_ZERO;
    end else begin
      off_reg <= off_next;
      div_reg <= div_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // ----------------------------------------------------------------
  // Shared sequential divider
  // ----------------------------------------------------------------
  // One restoring divider serves both channels in turn; this trades
  // 35 cycles per division, so 70 per channel refresh, for a single datapath.
  ais_state_type state_reg;   // Divider sequencer.
  ais_state_type state_next;
  logic ch_reg;               // Channel in work: 0 is one, 1 is two.
  logic ch_next;
  logic neg_reg;              // Quotient must be negated.
  logic neg_next;
  logic [32:0] quo_reg;       // Dividend shifting out, quotient in.
  logic [32:0] quo_next;
  logic [32:0] rem_reg;       // Partial remainder.
  logic [32:0] rem_next;
  logic [31:0] den_reg;       // Divisor magnitude.
  logic [31:0] den_next;
  logic [5:0] cnt_reg;        // Steps left.
  logic [5:0] cnt_next;
  logic [31:0] raw_sel;       // Raw count of the channel in work.
  logic [31:0] off_sel;       // Its offset.
  logic [31:0] div_sel;       // Its divisor.
  logic [32:0] sum_w;         // Offset-corrected reading, one guard bit.
  logic [33:0] rem_sh;        // Remainder after the shift.
  logic [33:0] rem_sub;       // Remainder less the divisor.
  logic [32:0] res_w;         // Signed quotient.

  // Select the operands by channel so each setting meets only its own.
  always_comb begin
    raw_sel = ch_reg ? raw_in.two : raw_in.one;
    off_sel = ch_reg ? off_reg.two : off_reg.one;
    div_sel = ch_reg ? div_reg.two : div_reg.one;
    sum_w = {raw_sel[31], raw_sel} + {off_sel[31], off_sel};
    rem_sh = {rem_reg, quo_reg[32]};
    rem_sub = rem_sh - {2'h0, den_reg};
    res_w = neg_reg ? -quo_reg : quo_reg;
  end

  // Next state of the divider.
  always_comb begin
    state_next = state_reg;
    ch_next = ch_reg;
    neg_next = neg_reg;
    quo_next = quo_reg;
    rem_next = rem_reg;
    den_next = den_reg;
    cnt_next = cnt_reg;
    scaled_next = scaled_reg;
    unique case (state_reg)
      AIS_ST_LOAD: begin
        // Work on magnitudes; the sign is applied at the end, so the
        // quotient truncates toward zero.
        neg_next = sum_w[32] ^ div_sel[31];
        quo_next = sum_w[32] ? -sum_w : sum_w;
        den_next = div_sel[31] ? -div_sel : div_sel;
        rem_next = '0;
        cnt_next = AIS_DIV_STEPS;
        state_next = AIS_ST_DIV;
      end
      AIS_ST_DIV: begin
        if (!rem_sub[33]) begin
          rem_next = rem_sub[32:0];
          quo_next = {quo_reg[31:0], 1'b1};
        end else begin
          rem_next = rem_sh[32:0];
          quo_next = {quo_reg[31:0], 1'b0};
        end
        cnt_next = cnt_reg - AIS_DIV_LAST;
        if (cnt_reg == AIS_DIV_LAST) begin
          state_next = AIS_ST_STORE;
        end
      end
      AIS_ST_STORE: begin
        // Only the low word is kept; a quotient beyond 32 bits wraps.
        if (ch_reg) begin
          scaled_next.two = res_w[31:0];
        end else begin
          scaled_next.one = res_w[31:0];
        end
        ch_next = ~ch_reg;
        state_next = AIS_ST_LOAD;
      end
      default: begin
        // The unused code recovers to a fresh load.
        state_next = AIS_ST_LOAD;
      end
    endcase
  end

  // Register the divider state.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= AIS_ST_LOAD;
      ch_reg <= 1'b0;
      neg_reg <= 1'b0;
      quo_reg <= '0;
      rem_reg <= '0;
      den_reg <= AIS_DIV_RST;
      cnt_reg <= '0;
      scaled_reg <= '{two: AIS_ZERO, one: AIS_ZERO};
    end else begin
      state_reg <= state_next;
      ch_reg <= ch_next;
      neg_reg <= neg_next;
      quo_reg <= quo_next;
      rem_reg <= rem_next;
      den_reg <= den_next;
      cnt_reg <= cnt_next;
      scaled_reg <= scaled_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a flip-flop.
  assign rd_data_out = rd_data_reg;
  assign scaled_out = scaled_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [31:0] exp_reg;      // Reference quotient taken at load.
  logic [31:0] raw_cap_reg;  // Raw count taken at load.
  logic plain_reg;           // Settings were at reset values at load.

  // Reference model uses the language's own signed division.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      exp_reg <= AIS_ZERO;
      raw_cap_reg <= AIS_ZERO;
      plain_reg <= 1'b0;
    end else if (state_reg == AIS_ST_LOAD) begin
      exp_reg <= 32'($signed(sum_w) / $signed({div_sel[31], div_sel}));
      raw_cap_reg <= raw_sel;
      plain_reg <= (off_sel == AIS_OFF_RST) && (div_sel == AIS_DIV_RST);
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_load;
    state_reg == AIS_ST_LOAD;
  endsequence

  sequence s_store;
    state_reg == AIS_ST_STORE;
  endsequence

  a_div_zero_refused: assert property (
    wr_en_in && (addr_in == AIS_ADDR_DIV_ONE) && (wr_data_in == AIS_ZERO)
    |=> div_reg.one == $past(div_reg.one))
    else $error("zero divisor write was taken");

  a_div_write_taken: assert property (
    wr_en_in && (addr_in == AIS_ADDR_DIV_TWO) && (wr_data_in != AIS_ZERO)
    |=> (div_reg.two == $past(wr_data_in)) && $stable(div_reg.one))
    else $error("divisor write landed wrongly");

  a_off_write_taken: assert property (
    wr_en_in && (addr_in == AIS_ADDR_OFF_ONE)
    |=> (off_reg.one == $past(wr_data_in)) && $stable(off_reg.two))
    else $error("offset write landed wrongly");

  a_count_read_two: assert property (
    rd_en_in && ((addr_in == AIS_ADDR_OFF_CNT) || (addr_in == AIS_ADDR_DIV_CNT))
    |=> rd_data_out == AIS_CHAN_COUNT)
    else $error("channel count read wrong");

  a_div_never_zero: assert property (
    (div_reg.one != AIS_ZERO) && (div_reg.two != AIS_ZERO))
    else $error("divisor holds zero");

  a_div_step_count: assert property (
    s_load |-> ##34 s_store)
    else $error("division did not finish in 34 cycles");

  a_result_matches: assert property (
    s_store |=> (($past(ch_reg) ? scaled_out.two : scaled_out.one) == exp_reg))
    else $error("scaled value differs from reference");

  a_reset_identity: assert property (
    s_store ##0 plain_reg
    |=> (($past(ch_reg) ? scaled_out.two : scaled_out.one) == raw_cap_reg))
    else $error("default settings did not pass raw count");

  a_other_chan_kept: assert property (
    s_store ##0 !ch_reg |=> $stable(scaled_out.two))
    else $error("store disturbed the other channel");

  a_zero_kept_two: assert property (
    wr_en_in && (addr_in == AIS_ADDR_DIV_TWO) && (wr_data_in == AIS_ZERO)
    |=> div_reg.two == $past(div_reg.two))
    else $error("zero divisor write was taken on channel two");

  a_div_one_taken: assert property (
    wr_en_in && (addr_in == AIS_ADDR_DIV_ONE) && (wr_data_in != AIS_ZERO)
    |=> (div_reg.one == $past(wr_data_in)) && $stable(div_reg.two))
    else $error("divisor write to channel one landed wrongly");

  a_off_two_taken: assert property (
    wr_en_in && (addr_in == AIS_ADDR_OFF_TWO)
    |=> (off_reg.two == $past(wr_data_in)) && $stable(off_reg.one))
    else $error("offset write to channel two landed wrongly");

  a_div_read_back: assert property (
    rd_en_in && (addr_in == AIS_ADDR_DIV_ONE)
    |=> rd_data_out == $past(div_reg.one))
    else $error("divisor read back wrong");

endmodule : ais_scaler

// ---- design/ais_pkg.sv ----
package ais_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int AIS_DW = 32;                // Data width of every entry.
  localparam int AIS_AW = 8;                 // Register address width.

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] AIS_ADDR_OFF_CNT = 8'h00;  // Offset channel count.
  localparam logic [7:0] AIS_ADDR_OFF_ONE = 8'h04;  // Offset, channel 1.
  localparam logic [7:0] AIS_ADDR_OFF_TWO = 8'h08;  // Offset, channel 2.
  localparam logic [7:0] AIS_ADDR_DIV_CNT = 8'h0c;  // Divisor channel count.
  localparam logic [7:0] AIS_ADDR_DIV_ONE = 8'h10;  // Divisor, channel 1.
  localparam logic [7:0] AIS_ADDR_DIV_TWO = 8'h14;  // Divisor, channel 2.
  localparam logic [7:0] AIS_ADDR_RES_ONE = 8'h18;  // Scaled value, channel 1.
  localparam logic [7:0] AIS_ADDR_RES_TWO = 8'h1c;  // Scaled value, channel 2.

  // ----------------------------------------------------------------
  // Reset values and fixed answers
  // ----------------------------------------------------------------
  localparam logic [31:0] AIS_CHAN_COUNT = 32'h0000_0002;  // Count entry word.
  localparam logic [31:0] AIS_OFF_RST = 32'h0000_0000;     // Offset reset.
  localparam logic [31:0] AIS_DIV_RST = 32'h0000_0001;     // Divisor reset.
  localparam logic [31:0] AIS_ZERO = 32'h0000_0000;        // Forbidden divisor.
  localparam logic [5:0] AIS_DIV_STEPS = 6'h21;            // 33 quotient bits.
  localparam logic [5:0] AIS_DIV_LAST = 6'h01;             // Final step count.

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // One 32-bit word for each of the two channels.
  typedef struct packed {
    logic [31:0] two;
    logic [31:0] one;
  } ais_pair_type;

  // Sequencer of the shared divider.
  typedef enum logic [1:0] {
    AIS_ST_LOAD = 2'b00,
    AIS_ST_DIV = 2'b01,
    AIS_ST_STORE = 2'b10
  } ais_state_type;

endpackage : ais_pkg

// ---- bench/tb_top.sv ----
module tb_top import ais_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------
  logic sys_clk_in;                // Bench clock, 50 MHz.
  logic arst_n_in;                 // Asynchronous reset, active low.
  ais_pair_type raw_in;            // Raw converter counts.
  logic [AIS_AW-1:0] addr_in;      // Register address.
  logic [AIS_DW-1:0] wr_data_in;   // Register write data.
  logic wr_en_in;                  // Write strobe.
  logic rd_en_in;                  // Read strobe.
  logic [AIS_DW-1:0] rd_data_out;  // Read answer.
  ais_pair_type scaled_out;        // Scaled values.
  logic [31:0] exp_q[$];           // Expected read answers, oldest first.
  logic rd_pend = 1'b0;            // A read was taken at the last edge.
  int n_errors = 0;                // Mismatches seen.
  int checks_done = 0;             // Comparisons made.
  int cycles = 0;                  // Cycles since time zero.
  ais_pair_type offs;              // Offsets as last written.
  ais_pair_type divs;              // Divisors as last accepted.

  ais_scaler ais_scaler_inst (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .raw_in(raw_in),
    .addr_in(addr_in),
    .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out),
    .scaled_out(scaled_out)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compares one word; case inequality so that an unknown never matches.
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check_word

  // Prints the verdict and ends the run.
  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // One-cycle write; the strobe drops at the next edge, so calls never collide.
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge sys_clk_in);
    wr_en_in <= 1'b0;
  endtask : reg_write

  // One-cycle read; the expected answer is queued for the monitor.
  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    exp_q.push_back(exp);
    @(posedge sys_clk_in);
    rd_en_in <= 1'b0;
  endtask : reg_read

  // Reference scaling: 33-bit signed sum, quotient truncated toward zero.
  function automatic logic [31:0] scale(input logic [31:0] r, o, d);
    longint s;
    longint q;
    s = longint'($signed(r)) + longint'($signed(o));
    q = s / longint'($signed(d));
    return q[31:0];
  endfunction : scale

  // Waits 120 cycles: a division in flight, then both channels reload and store (up to three rounds of 35).
  task automatic check_scaled;
    repeat (120) @(posedge sys_clk_in);
    check_word("scaled one", scale(raw_in.one, offs.one, divs.one), scaled_out.one);
    check_word("scaled two", scale(raw_in.two, offs.two, divs.two), scaled_out.two);
    reg_read(AIS_ADDR_RES_ONE, scale(raw_in.one, offs.one, divs.one));
    reg_read(AIS_ADDR_RES_TWO, scale(raw_in.two, offs.two, divs.two));
  endtask : check_scaled

  // ----------------------------------------------------------------
  // Clock, watchdog and read monitor
  // ----------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  // Cuts a hang short; the tests need under two thousand cycles.
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      stop_test();
    end
  end

  // The answer stands only in the cycle after the strobe, so it is taken then.
  always @(posedge sys_clk_in) begin
    if (rd_pend && exp_q.size() > 0) begin
      check_word("read data", exp_q.pop_front(), rd_data_out);
    end
    rd_pend <= rd_en_in;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    raw_in = '0;
    addr_in = '0;
    wr_data_in = '0;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    arst_n_in = 1'b0;
    offs = {AIS_OFF_RST, AIS_OFF_RST};
    divs = {AIS_DIV_RST, AIS_DIV_RST};
    void'($urandom(76));
    repeat (2) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    raw_in <= {$urandom, $urandom};
    // Reset values, then writes to read-only places and a read of an unmapped one.
    reg_read(AIS_ADDR_OFF_CNT, AIS_CHAN_COUNT);
    reg_read(AIS_ADDR_DIV_CNT, AIS_CHAN_COUNT);
    reg_read(AIS_ADDR_OFF_ONE, AIS_OFF_RST);
    reg_read(AIS_ADDR_OFF_TWO, AIS_OFF_RST);
    reg_read(AIS_ADDR_DIV_ONE, AIS_DIV_RST);
    reg_read(AIS_ADDR_DIV_TWO, AIS_DIV_RST);
    reg_write(AIS_ADDR_OFF_CNT, 32'h0000_00ff);
    reg_write(AIS_ADDR_DIV_CNT, 32'h0000_0005);
    reg_read(8'h20, 32'h0000_0000);
    reg_read(AIS_ADDR_OFF_CNT, AIS_CHAN_COUNT);
    reg_read(AIS_ADDR_DIV_CNT, AIS_CHAN_COUNT);
    check_scaled();
    // Random settings per channel, with boundary divisors in the first rounds.
    for (int i = 0; i < 8; i++) begin
      raw_in <= {$urandom, $urandom};
      offs = {$urandom, $urandom};
      for (int c = 0; c < 2; c++) begin
        d = $urandom >> ($urandom % 32);
        if ($urandom % 2) begin
          d = -d;
        end
        if (i == 0) begin
          d = 32'hffff_ffff;
        end
        if (i == 1) begin
          d = 32'h8000_0000;
        end
        if (d == AIS_ZERO) begin
          d = 32'h0000_0003;
        end
        if (c == 0) divs.one = d;
        else divs.two = d;
      end
      reg_write(AIS_ADDR_OFF_ONE, offs.one);
      reg_write(AIS_ADDR_OFF_TWO, offs.two);
      reg_write(AIS_ADDR_DIV_ONE, divs.one);
      reg_write(AIS_ADDR_DIV_TWO, divs.two);
      // A zero divisor is refused on one channel, the other keeps its own.
      reg_write((i % 2) ? AIS_ADDR_DIV_TWO : AIS_ADDR_DIV_ONE, AIS_ZERO);
      reg_read(AIS_ADDR_DIV_ONE, divs.one);
      reg_read(AIS_ADDR_DIV_TWO, divs.two);
      reg_read(AIS_ADDR_OFF_ONE, offs.one);
      reg_read(AIS_ADDR_OFF_TWO, offs.two);
      check_scaled();
    end
    repeat (3) @(posedge sys_clk_in);
    // Every queued read must have been answered and compared.
    check_word("pending reads", AIS_ZERO, 32'(exp_q.size()));
    stop_test();
  end

endmodule : tb_top
